// [hw/stc_pkg.sv]
package stc_pkg;
   // ==========================================================
   // register byte offsets on the bus
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_COUNT_LOW = 8'h04;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'h08;
   localparam logic [7:0] ADDR_FLAG = 8'h0c;
   localparam logic [7:0] ADDR_ENABLE = 8'h10;
   localparam logic [7:0] ADDR_CMP_MODE = 8'h14;
   localparam logic [7:0] ADDR_CMP_VALUE = 8'h18;
   localparam logic [7:0] ADDR_PORT = 8'h1c;

   // ==========================================================
   // timer_control_reg field positions
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_CLK_SRC_BIT = 1;
   localparam int CTRL_EXT_SYNC_BIT = 2;
   localparam int CTRL_OSC_EN_BIT = 3;
   localparam int CTRL_PRESCALE_LSB = 4;
   localparam int CTRL_WIDE_BIT = 7;
   // flag and enable registers hold their bit at position zero
   localparam int OVERFLOW_BIT = 0;
   // port register fields
   localparam int PORT_DIR_LSB = 0;
   localparam int PORT_OUT_LSB = 2;
   localparam int PORT_PIN_LSB = 4;

   // ==========================================================
   // values after reset
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [7:0] HBUF_RESET = 8'h00;
   localparam logic [3:0] CMP_MODE_RESET = 4'h0;
   localparam logic [15:0] CMP_VALUE_RESET = 16'h0000;
   localparam logic [1:0] PORT_DIR_RESET = 2'h3;
   localparam logic [1:0] PORT_OUT_RESET = 2'h0;

   // ==========================================================
   // codes and counts
   localparam logic [3:0] CMP_MODE_SPECIAL_TRIG = 4'hb;
   localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
   localparam int INSTR_DIV = 4;
   localparam int PRESCALE_MAX = 8;
endpackage

// [hw/stc_sync.sv]
`timescale 1ns/1ps
module stc_sync #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // asynchronous inputs
   input wire logic [WIDTH-1:0] i_async,
   // synchronised level and rising edge pulse
   output logic [WIDTH-1:0] o_level,
   output logic [WIDTH-1:0] o_rise
);
   genvar g;
   // ==========================================================
   // two flops per bit, a third flop feeds only the edge detector
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         logic meta_reg;
         logic sync_reg;
         logic last_reg;
         always_ff @(posedge i_clk) begin
            if (i_rst) begin
               meta_reg <= 1'b0;
               sync_reg <= 1'b0;
               last_reg <= 1'b0;
            end else begin
               meta_reg <= i_async[g];
               sync_reg <= meta_reg;
               last_reg <= sync_reg;
            end
         end
         assign o_level[g] = sync_reg;
         assign o_rise[g] = sync_reg & ~last_reg;
      end
   endgenerate
endmodule

// [hw/stc_prescale.sv]
`timescale 1ns/1ps
module stc_prescale #(
   parameter int MAX_DIV = stc_pkg::PRESCALE_MAX
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // selected source tick, clear and divide code
   input wire logic i_tick,
   input wire logic i_clear,
   input wire logic [1:0] i_sel,
   // one pulse per divided period
   output logic o_inc
);
   localparam int CW = $clog2(MAX_DIV);
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic [CW-1:0] mask;
   logic wrap;

   // ==========================================================
   // code 00..11 gives 1:1, 1:2, 1:4, 1:8
   assign mask = CW'((1 << i_sel) - 1);
   assign wrap = (cnt_reg & mask) == mask;
   assign o_inc = i_tick & wrap & ~i_clear;
   assign cnt_next = i_clear ? '0 : (i_tick ? (wrap ? '0 : cnt_reg + 1'b1) : cnt_reg);

   // count state
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
endmodule

// [hw/stc_top.sv]
// Contract
// R1: clock select clear: count advances once per instruction cycle.
// R2: clock select set: count advances on rising edges of pin or oscillator.
// R3: oscillator enabled forces both crystal pins to inputs reading zero.
// R4: oscillator starts when its enable bit is set; runs in all modes.
// R5: software waits for oscillator start-up before relying on it.
// R6: sixteen-bit count runs from zero to all ones then wraps to zero.
// R7: each wrap sets the overflow flag at bit zero of flag register.
// R8: overflow interrupt request only while enable bit zero is set.
// R9: special trigger mode: trigger clears count and starts conversion if enabled.
// R10: trigger clear never sets the overflow flag.
// R11: software uses timer or synchronised mode for trigger clear.
// R12: software count write wins over a coincident trigger clear.
// R13: compare value acts as period; count restarts at zero on match.
// R14: wide mode maps high address to buffer; low read copies live high.
// R15: wide mode high writes hit buffer; low write loads buffer into high.
// R16: wide mode makes live high byte unreachable directly.
// R17: high byte writes keep the prescaler; low byte writes clear it.
// R18: prescale code 11,10,01,00 divides by 8,4,2,1.
// R19: sync select acts only with the external source selected.
// R20: counting only while run bit zero of control is set.
// R21: overflow flag stays set until software writes zero.
// R22: synchronised external edges pass a synchroniser before counting.
//
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module stc_top (
   // clock and reset
   input wire logic I_CLOCK,
   input wire logic I_SYS_RST,
   // ahb-lite slave
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   output logic [31:0] O_HRDATA,
   output logic O_HREADYOUT,
   output logic O_HRESP,
   // crystal pins, split into in, out and active-low enable
   input wire logic I_CRYSTAL_IN_PIN,
   output logic O_CRYSTAL_IN_PIN,
   output logic O_CRYSTAL_IN_OE_N,
   input wire logic I_CRYSTAL_OUT_PIN,
   output logic O_CRYSTAL_OUT_PIN,
   output logic O_CRYSTAL_OUT_OE_N,
   // oscillator cell control
   output logic O_OSC_ENABLE,
   // converter link
   input wire logic I_ADC_ENABLE,
   output logic O_ADC_START,
   // overflow interrupt request
   output logic O_OVERFLOW_IRQ
);
   // ==========================================================
   // bus state
   logic dp_wr_reg;
   logic dp_wr_next;
   logic rd_wait_reg;
   logic rd_wait_next;
   logic [7:0] dp_addr_reg;
   logic [7:0] dp_addr_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic addr_phase;

   // ==========================================================
   // software-visible state
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [15:0] count_reg;
   logic [15:0] count_next;
   logic [7:0] hbuf_reg;
   logic [7:0] hbuf_next;
   logic flag_reg;
   logic flag_next;
   logic irq_en_reg;
   logic irq_en_next;
   logic [3:0] cmp_mode_reg;
   logic [3:0] cmp_mode_next;
   logic [15:0] cmp_value_reg;
   logic [15:0] cmp_value_next;
   logic [1:0] port_dir_reg;
   logic [1:0] port_dir_next;
   logic [1:0] port_out_reg;
   logic [1:0] port_out_next;

   // ==========================================================
   // timing state
   logic [1:0] instr_cnt_reg;
   logic [1:0] instr_cnt_next;
   logic match_last_reg;
   logic adc_start_reg;

   // ==========================================================
   // control fields
   wire run = ctrl_reg[stc_pkg::CTRL_RUN_BIT];
   wire clk_src = ctrl_reg[stc_pkg::CTRL_CLK_SRC_BIT];
   wire ext_sync = ctrl_reg[stc_pkg::CTRL_EXT_SYNC_BIT];
   wire osc_en = ctrl_reg[stc_pkg::CTRL_OSC_EN_BIT];
   wire wide = ctrl_reg[stc_pkg::CTRL_WIDE_BIT];
   wire [1:0] prescale = ctrl_reg[stc_pkg::CTRL_PRESCALE_LSB +: 2];
   // unsynchronised mode only exists with the external source selected
   wire async_mode = clk_src & ext_sync; // R19

   // ==========================================================
   // bus decode: writes finish with no wait, reads take one wait state
   // so a read issued right behind a write sees the written value
   assign addr_phase = I_HSEL & I_HREADY & I_HTRANS[1];
   assign dp_wr_next = addr_phase & I_HWRITE;
   assign rd_wait_next = addr_phase & ~I_HWRITE;
   assign dp_addr_next = addr_phase ? I_HADDR[7:0] : dp_addr_reg;
   assign O_HREADYOUT = ~rd_wait_reg;
   assign O_HRESP = 1'b0;
   assign O_HRDATA = rdata_reg;

   // strobes, all taken in the data phase
   wire wr_ctrl = dp_wr_reg & (dp_addr_reg == stc_pkg::ADDR_CTRL);
   wire wr_low = dp_wr_reg & (dp_addr_reg == stc_pkg::ADDR_COUNT_LOW);
   wire wr_high = dp_wr_reg & (dp_addr_reg == stc_pkg::ADDR_COUNT_HIGH);
   wire wr_flag = dp_wr_reg & (dp_addr_reg == stc_pkg::ADDR_FLAG);
   wire wr_enable = dp_wr_reg & (dp_addr_reg == stc_pkg::ADDR_ENABLE);
   wire wr_cmp_mode = dp_wr_reg & (dp_addr_reg == stc_pkg::ADDR_CMP_MODE);
   wire wr_cmp_value = dp_wr_reg & (dp_addr_reg == stc_pkg::ADDR_CMP_VALUE);
   wire wr_port = dp_wr_reg & (dp_addr_reg == stc_pkg::ADDR_PORT);
   wire rd_low = rd_wait_reg & (dp_addr_reg == stc_pkg::ADDR_COUNT_LOW);
   wire [7:0] wbyte = I_HWDATA[7:0];

   // ==========================================================
   // pin synchroniser, bit 0 crystal input, bit 1 crystal output pin
   logic [1:0] pin_level;
   logic [1:0] pin_rise;

   stc_sync #(
      .WIDTH(2)
   ) u_sync (
      .i_clk(I_CLOCK),
      .i_rst(I_SYS_RST),
      .i_async({I_CRYSTAL_OUT_PIN, I_CRYSTAL_IN_PIN}),
      .o_level(pin_level),
      .o_rise(pin_rise)
   );

   // ==========================================================
   // pins: an enabled oscillator owns both pins, direction bits then ignored
   assign O_CRYSTAL_IN_OE_N = port_dir_reg[0] | osc_en; // R3
   assign O_CRYSTAL_OUT_OE_N = port_dir_reg[1] | osc_en; // R3
   assign O_CRYSTAL_IN_PIN = port_out_reg[0];
   assign O_CRYSTAL_OUT_PIN = port_out_reg[1];
   wire [1:0] pin_read = osc_en ? 2'h0 : pin_level; // R3
   // the analog cell has no power-mode gate: only this bit stops it
   assign O_OSC_ENABLE = osc_en; // R4

   // ==========================================================
   // tick sources: instruction cycle is a quarter of the system clock
   wire instr_tick = instr_cnt_reg == 2'(stc_pkg::INSTR_DIV - 1); // R1
   assign instr_cnt_next = instr_tick ? 2'h0 : instr_cnt_reg + 2'h1;
   // oscillator output appears on the crystal input pin when enabled
   wire ext_rise = osc_en ? pin_rise[0] : pin_rise[1]; // R2 R22
   wire src_tick = (clk_src ? ext_rise : instr_tick) & run; // R1 R2 R20

   // prescaler, cleared only by a low byte write
   logic inc;

   stc_prescale #(
      .MAX_DIV(stc_pkg::PRESCALE_MAX)
   ) u_prescale (
      .i_clk(I_CLOCK),
      .i_rst(I_SYS_RST),
      .i_tick(src_tick),
      .i_clear(wr_low), // R17
      .i_sel(prescale), // R18
      .o_inc(inc)
   );

   // ==========================================================
   // special event trigger from compare match
   // rising edge of match, so a period of zero does not retrigger forever
   wire trig_mode = cmp_mode_reg == stc_pkg::CMP_MODE_SPECIAL_TRIG; // R9
   wire match = trig_mode & (count_reg == cmp_value_reg); // R13
   wire trig = match & ~match_last_reg;
   // the clear is not honoured in unsynchronised mode
   wire trig_clr = trig & ~async_mode; // R11
   wire any_count_wr = wr_low | (wr_high & ~wide);

   // ==========================================================
   // count: write beats trigger clear beats increment
   always_comb begin
      count_next = count_reg;
      if (wr_low) begin
         count_next = {wide ? hbuf_reg : count_reg[15:8], wbyte}; // R15
      end else if (wr_high & ~wide) begin
         count_next = {wbyte, count_reg[7:0]}; // R16
      end else if (trig_clr) begin
         count_next = stc_pkg::COUNT_RESET; // R9 R12
      end else if (inc) begin
         count_next = count_reg + 16'h0001; // R6
      end
   end

   // overflow only from a real wrap, never from the trigger clear
   wire wrap = inc & (count_reg == stc_pkg::COUNT_ALL_ONES) & ~trig_clr & ~any_count_wr; // R7 R10
   // set wins over a coincident software clear
   assign flag_next = wrap | (wr_flag ? I_HWDATA[stc_pkg::OVERFLOW_BIT] : flag_reg); // R21
   assign O_OVERFLOW_IRQ = flag_reg & irq_en_reg; // R8

   // ==========================================================
   // high byte buffer
   always_comb begin
      hbuf_next = hbuf_reg;
      if (wr_high & wide) begin
         hbuf_next = wbyte; // R15
      end else if (rd_low & wide) begin
         hbuf_next = count_reg[15:8]; // R14
      end
   end

   // plain register writes
   assign ctrl_next = wr_ctrl ? wbyte : ctrl_reg;
   assign irq_en_next = wr_enable ? I_HWDATA[stc_pkg::OVERFLOW_BIT] : irq_en_reg;
   assign cmp_mode_next = wr_cmp_mode ? I_HWDATA[3:0] : cmp_mode_reg;
   assign cmp_value_next = wr_cmp_value ? I_HWDATA[15:0] : cmp_value_reg;
   assign port_dir_next = wr_port ? I_HWDATA[stc_pkg::PORT_DIR_LSB +: 2] : port_dir_reg;
   assign port_out_next = wr_port ? I_HWDATA[stc_pkg::PORT_OUT_LSB +: 2] : port_out_reg;

   // ==========================================================
   // read mux, sampled in the wait cycle; unmapped reads return zero
   wire [7:0] high_view = wide ? hbuf_reg : count_reg[15:8]; // R14 R16
   always_comb begin
      rdata_next = rdata_reg;
      if (rd_wait_reg) begin
         rdata_next = 32'h0000_0000;
         if (dp_addr_reg == stc_pkg::ADDR_CTRL) begin
            rdata_next[7:0] = ctrl_reg;
         end else if (dp_addr_reg == stc_pkg::ADDR_COUNT_LOW) begin
            rdata_next[7:0] = count_reg[7:0];
         end else if (dp_addr_reg == stc_pkg::ADDR_COUNT_HIGH) begin
            rdata_next[7:0] = high_view;
         end else if (dp_addr_reg == stc_pkg::ADDR_FLAG) begin
            rdata_next[stc_pkg::OVERFLOW_BIT] = flag_reg;
         end else if (dp_addr_reg == stc_pkg::ADDR_ENABLE) begin
            rdata_next[stc_pkg::OVERFLOW_BIT] = irq_en_reg;
         end else if (dp_addr_reg == stc_pkg::ADDR_CMP_MODE) begin
            rdata_next[3:0] = cmp_mode_reg;
         end else if (dp_addr_reg == stc_pkg::ADDR_CMP_VALUE) begin
            rdata_next[15:0] = cmp_value_reg;
         end else if (dp_addr_reg == stc_pkg::ADDR_PORT) begin
            rdata_next[stc_pkg::PORT_DIR_LSB +: 2] = port_dir_reg;
            rdata_next[stc_pkg::PORT_OUT_LSB +: 2] = port_out_reg;
            rdata_next[stc_pkg::PORT_PIN_LSB +: 2] = pin_read; // R3
         end
      end
   end

   // ==========================================================
   // bus flops
   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         dp_wr_reg <= 1'b0;
         rd_wait_reg <= 1'b0;
         dp_addr_reg <= 8'h00;
         rdata_reg <= 32'h0000_0000;
      end else begin
         dp_wr_reg <= dp_wr_next;
         rd_wait_reg <= rd_wait_next;
         dp_addr_reg <= dp_addr_next;
         rdata_reg <= rdata_next;
      end
   end

   // counting flops
   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         count_reg <= stc_pkg::COUNT_RESET;
         hbuf_reg <= stc_pkg::HBUF_RESET;
         flag_reg <= 1'b0;
         instr_cnt_reg <= 2'h0;
         match_last_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         hbuf_reg <= hbuf_next;
         flag_reg <= flag_next;
         instr_cnt_reg <= instr_cnt_next;
         match_last_reg <= match;
      end
   end

   // configuration flops
   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         ctrl_reg <= stc_pkg::CTRL_RESET;
         irq_en_reg <= 1'b0;
         cmp_mode_reg <= stc_pkg::CMP_MODE_RESET;
         cmp_value_reg <= stc_pkg::CMP_VALUE_RESET;
         port_dir_reg <= stc_pkg::PORT_DIR_RESET;
         port_out_reg <= stc_pkg::PORT_OUT_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
         irq_en_reg <= irq_en_next;
         cmp_mode_reg <= cmp_mode_next;
         cmp_value_reg <= cmp_value_next;
         port_dir_reg <= port_dir_next;
         port_out_reg <= port_out_next;
      end
   end

   // ==========================================================
   // conversion start pulse, one cycle, registered
   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         adc_start_reg <= 1'b0;
      end else begin
         adc_start_reg <= trig & I_ADC_ENABLE; // R9
      end
   end
   assign O_ADC_START = adc_start_reg;
endmodule

// [test/stc_sva.sv]
`timescale 1ns/1ps
// ==========================================================
// port-level checks
module stc_sva (
   // clock and reset
   input wire logic I_CLOCK,
   input wire logic I_SYS_RST,
   // bus signals
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic I_HREADY,
   input wire logic [31:0] O_HRDATA,
   input wire logic O_HREADYOUT,
   input wire logic O_HRESP,
   // pins and events
   input wire logic O_CRYSTAL_IN_OE_N,
   input wire logic O_CRYSTAL_OUT_OE_N,
   input wire logic O_OSC_ENABLE,
   input wire logic I_ADC_ENABLE,
   input wire logic O_ADC_START,
   input wire logic O_OVERFLOW_IRQ
);
   logic taken;
   logic wr_dp_reg;
   // accepted transfer
   assign taken = I_HSEL & I_HREADY & I_HTRANS[1];
   // write data phase marker
   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST)
         wr_dp_reg <= 1'b0;
      else if (I_HREADY)
         wr_dp_reg <= taken & I_HWRITE;
   end
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_SYS_RST);
   // ==========================================================
   // bus timing
   sequence s_one_wait;
      !O_HREADYOUT ##1 O_HREADYOUT;
   endsequence
   sequence s_port_read;
      taken && !I_HWRITE && I_HADDR[7:0] == stc_pkg::ADDR_PORT;
   endsequence
   property p_read_wait;
      taken && !I_HWRITE |=> s_one_wait;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read wait not one cycle");
   property p_write_nowait;
      taken && I_HWRITE |=> O_HREADYOUT;
   endproperty
   a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
   property p_okay;
      O_HRESP == 1'b0;
   endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
   // read data moves only after a wait
   property p_rdata_hold;
      !$stable(O_HRDATA) |-> $past(O_HREADYOUT) == 1'b0;
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   // ==========================================================
   // pins, oscillator and events
   property p_pins_in;
      O_OSC_ENABLE |-> O_CRYSTAL_IN_OE_N && O_CRYSTAL_OUT_OE_N;
   endproperty
   a_pins_in: assert property (p_pins_in) else $error("crystal pin driven");
   property p_port_zero;
      s_port_read ##1 O_OSC_ENABLE |=> O_HRDATA[5:4] == 2'b00;
   endproperty
   a_port_zero: assert property (p_port_zero) else $error("pin level seen");
   property p_osc_cause;
      !$stable(O_OSC_ENABLE) |-> $past(wr_dp_reg);
   endproperty
   a_osc_cause: assert property (p_osc_cause) else $error("oscillator moved alone");
   property p_irq_fall;
      $fell(O_OVERFLOW_IRQ) |-> $past(wr_dp_reg);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("request dropped alone");
   property p_adc_pulse;
      O_ADC_START |=> !O_ADC_START;
   endproperty
   a_adc_pulse: assert property (p_adc_pulse) else $error("start pulse too long");
   property p_adc_gate;
      O_ADC_START |-> $past(I_ADC_ENABLE);
   endproperty
   a_adc_gate: assert property (p_adc_gate) else $error("start while disabled");
endmodule

bind stc_top stc_sva sva_u (
   .I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR),
   .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA),
   .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_CRYSTAL_IN_OE_N(O_CRYSTAL_IN_OE_N),
   .O_CRYSTAL_OUT_OE_N(O_CRYSTAL_OUT_OE_N), .O_OSC_ENABLE(O_OSC_ENABLE),
   .I_ADC_ENABLE(I_ADC_ENABLE), .O_ADC_START(O_ADC_START), .O_OVERFLOW_IRQ(O_OVERFLOW_IRQ)
);

// [test/stc_clk_src.sv]
`timescale 1ns/1ps
// ==========================================================
// far side: crystal and external clock
module stc_clk_src #(
   parameter int HALF_NS = 150
) (
   // controls
   input wire logic i_osc_en,
   input wire logic i_ext_en,
   input wire logic i_slow,
   // pins and rise count
   output logic o_xin,
   output logic o_xout,
   output int o_rises
);
   // crystal swings only while enabled
   initial begin
      o_xin = 1'b0;
      forever begin
         wait (i_osc_en);
         #(HALF_NS);
         o_xin = i_osc_en & ~o_xin;
      end
   end
   always @(negedge i_osc_en) o_xin = 1'b0;
   // external clock, low between bursts; slow triples it
   initial begin
      o_xout = 1'b0;
      forever begin
         wait (i_ext_en);
         #(i_slow ? 3 * HALF_NS : HALF_NS);
         o_xout = i_ext_en & ~o_xout;
      end
   end
   always @(negedge i_ext_en) o_xout = 1'b0;
   initial o_rises = 0;
   always @(posedge o_xin or posedge o_xout) o_rises++;
endmodule

// [test/sixteen_bit_timer_counter_tb_top.sv]
`timescale 1ns/1ps
// ==========================================================
// timer/counter bench
module sixteen_bit_timer_counter_tb_top;
   logic clk, rst, hsel, hwrite, hready, hresp, xin_o, xin_oe_n, xout_o, xout_oe_n;
   logic osc_en, adc_en, adc_start, irq, ext_en, slow, src_xin, src_xout;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, v0, v1;
   wire xin_w, xout_w;
   int err_count = 0, checks_done = 0, rises, e0, e1;
   logic [7:0] ctl [6] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h05, 8'h00};
   logic [7:0] step [6] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h10, 8'h00};
   // the block wins while it drives
   assign xin_w = xin_oe_n ? src_xin : xin_o;
   assign xout_w = xout_oe_n ? src_xout : xout_o;
   stc_top dut_u (
      .I_CLOCK(clk), .I_SYS_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
      .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready),
      .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
      .I_CRYSTAL_IN_PIN(xin_w), .O_CRYSTAL_IN_PIN(xin_o), .O_CRYSTAL_IN_OE_N(xin_oe_n),
      .I_CRYSTAL_OUT_PIN(xout_w), .O_CRYSTAL_OUT_PIN(xout_o),
      .O_CRYSTAL_OUT_OE_N(xout_oe_n), .O_OSC_ENABLE(osc_en), .I_ADC_ENABLE(adc_en),
      .O_ADC_START(adc_start), .O_OVERFLOW_IRQ(irq)
   );
   stc_clk_src src_u (
      .i_osc_en(osc_en), .i_ext_en(ext_en), .i_slow(slow), .o_xin(src_xin),
      .o_xout(src_xout), .o_rises(rises)
   );
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // ==========================================================
   // bus and compare tasks
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clk);
      htrans <= 2'b10;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      bus(1'b0, a, 32'h00000000, d);
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
      logic [31:0] g;
      rd(a, g);
      chk(n, e, g);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // watchdog, about 3800 cycles needed
   initial begin
      repeat (40000) @(posedge clk);
      err_count++;
      complete_run();
   end
   // ==========================================================
   // main sequence
   initial begin
      rst = 1'b1; hsel = 1'b1; htrans = 2'b00; haddr = 32'h0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = 32'h0; adc_en = 1'b0; ext_en = 1'b0; slow = 1'b0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rchk(stc_pkg::ADDR_CTRL, 32'h00, "ctrl_rst");
      rchk(stc_pkg::ADDR_PORT, 32'h03, "port_rst");
      rchk(stc_pkg::ADDR_FLAG, 32'h00, "flag_rst");
      wr(8'h40, 32'h12345678);
      rchk(8'h40, 32'h00, "unmapped");
      // 64-clock advance per setting
      for (int i = 0; i < 6; i++) begin
         wr(stc_pkg::ADDR_CTRL, {24'h0, ctl[i]});
         repeat (40) @(posedge clk);
         rd(stc_pkg::ADDR_COUNT_LOW, v0);
         repeat (60) @(posedge clk);
         rd(stc_pkg::ADDR_COUNT_LOW, v1);
         chk("timer_step", {24'h0, step[i]}, {24'h0, v1[7:0] - v0[7:0]});
      end
      // wrap from all ones, flag and request gating
      wr(stc_pkg::ADDR_ENABLE, 32'h0);
      wr(stc_pkg::ADDR_COUNT_HIGH, 32'hff);
      wr(stc_pkg::ADDR_COUNT_LOW, 32'hfe);
      wr(stc_pkg::ADDR_FLAG, 32'h0);
      wr(stc_pkg::ADDR_CTRL, 32'h01);
      repeat (40) @(posedge clk);
      rchk(stc_pkg::ADDR_COUNT_HIGH, 32'h00, "wrap_high");
      rchk(stc_pkg::ADDR_FLAG, 32'h01, "ovf_flag");
      chk("irq_masked", 32'h0, {31'h0, irq});
      wr(stc_pkg::ADDR_ENABLE, 32'h1);
      @(posedge clk);
      chk("irq_on", 32'h1, {31'h0, irq});
      wr(stc_pkg::ADDR_FLAG, 32'h0);
      @(posedge clk);
      chk("irq_off", 32'h0, {31'h0, irq});
      // trigger clear; 1088 clocks is 17 periods
      adc_en <= 1'b1;
      wr(stc_pkg::ADDR_COUNT_HIGH, 32'h0);
      wr(stc_pkg::ADDR_COUNT_LOW, 32'h0);
      wr(stc_pkg::ADDR_CMP_VALUE, 32'h10);
      wr(stc_pkg::ADDR_CMP_MODE, 32'h0b);
      e0 = 0;
      while (adc_start !== 1'b1 && e0 < 200) begin
         @(posedge clk);
         e0++;
      end
      chk("adc_start", 32'h1, {31'h0, adc_start});
      rd(stc_pkg::ADDR_COUNT_LOW, v0);
      repeat (1084) @(posedge clk);
      rd(stc_pkg::ADDR_COUNT_LOW, v1);
      chk("period", v0, v1);
      chk("below_cmp", 32'h1, {31'h0, v0 <= 32'h10});
      rchk(stc_pkg::ADDR_FLAG, 32'h00, "trig_no_flag");
      wr(stc_pkg::ADDR_CMP_MODE, 32'h0);
      // wide access via the buffer
      wr(stc_pkg::ADDR_CTRL, 32'h80);
      wr(stc_pkg::ADDR_COUNT_HIGH, 32'h5a);
      rchk(stc_pkg::ADDR_COUNT_HIGH, 32'h5a, "buf_read");
      wr(stc_pkg::ADDR_COUNT_LOW, 32'h34);
      wr(stc_pkg::ADDR_COUNT_HIGH, 32'h77);
      wr(stc_pkg::ADDR_CTRL, 32'h00);
      rchk(stc_pkg::ADDR_COUNT_HIGH, 32'h5a, "live_high");
      rchk(stc_pkg::ADDR_COUNT_LOW, 32'h34, "live_low");
      wr(stc_pkg::ADDR_CTRL, 32'h80);
      rchk(stc_pkg::ADDR_COUNT_LOW, 32'h34, "wide_low");
      rchk(stc_pkg::ADDR_COUNT_HIGH, 32'h5a, "low_copy");
      // external clock, sync then unsync and slow
      for (int i = 0; i < 2; i++) begin
         wr(stc_pkg::ADDR_CTRL, (i == 1) ? 32'h07 : 32'h03);
         wr(stc_pkg::ADDR_COUNT_LOW, 32'h0);
         e0 = rises;
         slow <= (i == 1);
         ext_en <= 1'b1;
         repeat (600) @(posedge clk);
         ext_en <= 1'b0;
         repeat (10) @(posedge clk);
         rd(stc_pkg::ADDR_COUNT_LOW, v0);
         chk("ext_count", rises - e0, v0);
      end
      // driven pins, then oscillator takeover
      wr(stc_pkg::ADDR_CTRL, 32'h00);
      wr(stc_pkg::ADDR_PORT, 32'h0c);
      repeat (4) @(posedge clk);
      rchk(stc_pkg::ADDR_PORT, 32'h3c, "port_drive");
      wr(stc_pkg::ADDR_CTRL, 32'h0a);
      @(posedge clk);
      chk("osc_pins", 32'h7, {29'h0, osc_en, xin_oe_n, xout_oe_n});
      rchk(stc_pkg::ADDR_PORT, 32'h0c, "pins_zero");
      wr(stc_pkg::ADDR_COUNT_LOW, 32'h0);
      repeat (200) @(posedge clk);
      // run gated between crystal edges so no edge is in flight
      @(posedge src_xin);
      repeat (8) @(posedge clk);
      e0 = rises;
      wr(stc_pkg::ADDR_CTRL, 32'h0b);
      repeat (300) @(posedge clk);
      @(posedge src_xin);
      repeat (8) @(posedge clk);
      e1 = rises;
      wr(stc_pkg::ADDR_CTRL, 32'h0a);
      rchk(stc_pkg::ADDR_COUNT_LOW, e1 - e0, "osc_count");
      wr(stc_pkg::ADDR_CTRL, 32'h00);
      complete_run();
   end
endmodule
